// ==== src/rta_arbiter.sv ====
// Purpose: Decides when radio transmissions start and end, and trades
//          transmit against receive according to the protocol mode.
// Assumes: Inputs synchronous to mclk_i; character strobes from a UART.
// Notes:   Framing content (sync word, headers) is produced downstream on
//          the sync request; this block only sequences it.
`include "rta_cfg.svh"
module rta_arbiter
   import rta_pkg::*;
#(
   parameter int RESYNC_CYC = `RTA_RESYNC_CYC,  // Extra sync duration.
   parameter int MS_CYC     = `RTA_CYC_PER_MS   // Cycles per millisecond.
) (
   input  wire logic        mclk_i,          // Device clock, 100 MHz.
   input  wire logic        rst_i,           // Synchronous reset.
   input  wire logic        ce_i,            // Clock enable.
   input  wire logic        mode_valid_i,    // Load mode from mode_i.
   input  wire logic [2:0]  mode_i,          // Protocol mode code.
   input  wire logic [7:0]  pause_chars_i,   // Pause length, 0 = default.
   input  wire logic [15:0] char_cyc_i,      // Cycles per character time.
   input  wire logic [15:0] tx_delay_ms_i,   // Start delay, 0 = off.
   input  wire logic [15:0] sync_int_i,      // Bytes per frame, 0 = none.
   input  wire logic        term_valid_i,    // Terminal byte strobe.
   input  wire logic [7:0]  term_data_i,     // Terminal byte.
   input  wire logic        settings_cmd_i,  // Settings command seen.
   output logic             term_ready_o,    // Buffer accepts byte.
   input  wire logic        rx_start_i,      // Radio frame start found.
   input  wire logic        rx_adv_i,        // Sender in advanced mode.
   input  wire logic        rx_lost_i,       // Reception lost.
   input  wire logic        rx_end_i,        // Reception ended.
   input  wire logic        rx_ok_i,         // Message passed validation.
   input  wire logic        rx_fwd_i,        // Content asks for repeat.
   input  wire logic        rx_byte_i,       // Received byte strobe.
   input  wire logic        radio_ready_i,   // Modulator takes a byte.
   input  wire logic        fwd_done_i,      // Stored message resent.
   output logic             tx_on_o,         // Transmitter enabled.
   output logic             sync_req_o,      // Send sync and headers.
   output logic             tx_valid_o,      // Byte for modulator.
   output logic [7:0]       tx_data_o,       // Byte to modulator.
   output logic             fwd_req_o,       // Replay stored message.
   output logic             rx_accept_o,     // Reception being kept.
   output logic             rx_drop_o,       // Reception discarded.
   output logic             diag_en_o,       // Diagnostics enabled.
   output logic             overflow_o       // Buffer overflow seen while transmitting.
);
   typedef struct packed {
      rta_state_t  st;
      rta_mode_t   mode;
      logic [23:0] pause_cnt;
      logic [7:0]  pause_chars;
      logic        paused;
      logic [39:0] dly_cnt;
      logic [31:0] sync_cnt;
      logic [15:0] frame_bytes;
      logic [10:0] rpt_bytes;
      logic        rx_keep;
      logic        drop;
      logic        ovf;
      logic        out_valid;
      logic [7:0]  out_data;
   } rta_regs_t;

   rta_regs_t r;
   rta_regs_t next_r;
   logic       f_rvalid;
   logic [7:0] f_rdata;
   logic       f_empty;
   logic       f_ready;
   logic       f_pop;
   logic       ovf_ev;
   logic       frame_full;

   // Advanced modes are the master and slave codes.
   function automatic logic is_adv(input rta_mode_t m);
      return (m == RTA_MODE_ADV_MST) || (m == RTA_MODE_ADV_SLV);
   endfunction

   // Once the frame holds its byte limit, bytes wait in the FIFO for the next
   // frame; popping on would let a steady stream run past the limit forever.
   assign frame_full = (sync_int_i != 16'h0) && (r.frame_bytes >= sync_int_i);

   // Pop only while actually transmitting and the output slot is free.
   assign f_pop  = (r.st == RTA_ST_TX) && (!r.out_valid || radio_ready_i) && !frame_full;
   assign ovf_ev = term_valid_i && !f_ready;

   rta_fifo #(.WIDTH(`RTA_DATA_W), .DEPTH(`RTA_FIFO_DEPTH)) rta_fifo_i (
      .mclk_i   (mclk_i),
      .rst_i    (rst_i),
      .ce_i     (ce_i),
      .wvalid_i (term_valid_i),
      .wready_o (f_ready),
      .wdata_i  (term_data_i),
      .rvalid_o (f_rvalid),
      .rready_i (f_pop),
      .rdata_o  (f_rdata),
      .empty_o  (f_empty)
   );

   // Next-state logic for the whole arbiter.
   always_comb begin
      next_r      = r;
      next_r.drop = 1'b0;
      next_r.ovf  = 1'b0;
      if (mode_valid_i && mode_i <= 3'h4) begin
         next_r.mode = rta_mode_t'(mode_i);
      end
      next_r.pause_chars = (pause_chars_i == 8'h00) ? `RTA_PAUSE_DEF_CHARS
                                                     : pause_chars_i;
      // Idle timer restarts on each terminal character.
      if (term_valid_i) begin
         next_r.pause_cnt = '0;
         next_r.paused    = 1'b0;
      end else if (!r.paused) begin
         // Wide enough for the longest pause at the slowest bit rate.
         if (r.pause_cnt >= 24'(char_cyc_i) * 24'(r.pause_chars) - 24'h1) begin
            next_r.paused = 1'b1;
         end else begin
            next_r.pause_cnt = r.pause_cnt + 24'h1;
         end
      end
      if (r.out_valid && radio_ready_i) begin
         next_r.out_valid = 1'b0;
      end
      if (f_pop && f_rvalid) begin
         next_r.out_valid   = 1'b1;
         next_r.out_data    = f_rdata;
         next_r.frame_bytes = r.frame_bytes + 16'h1;
      end
      unique case (r.st)
         RTA_ST_IDLE: begin
            if (rx_start_i) begin
               if (is_adv(r.mode) != rx_adv_i) begin
                  next_r.drop = 1'b1;
               end else begin
                  next_r.st        = RTA_ST_RX;
                  next_r.rx_keep   = 1'b1;
                  next_r.rpt_bytes = '0;
               end
            end else if (!f_empty) begin
               // The longest delay in cycles does not fit in 32 bits.
               next_r.dly_cnt = 40'(tx_delay_ms_i) * 40'(MS_CYC);
               next_r.st      = (tx_delay_ms_i == 16'h0) ? RTA_ST_SYNC
                                                         : RTA_ST_DELAY;
               next_r.sync_cnt = '0;
            end
         end
         RTA_ST_DELAY: begin
            if (r.dly_cnt <= 40'h1) begin
               next_r.st = RTA_ST_SYNC;
            end else begin
               next_r.dly_cnt = r.dly_cnt - 40'h1;
            end
         end
         RTA_ST_SYNC: begin
            // Sync and headers go out only here, at the head of a frame.
            if (r.sync_cnt >= 32'(RESYNC_CYC) - 32'h1) begin
               next_r.st          = RTA_ST_TX;
               next_r.frame_bytes = '0;
            end else begin
               next_r.sync_cnt = r.sync_cnt + 32'h1;
            end
         end
         RTA_ST_TX: begin
            if (ovf_ev) begin
               next_r.st  = RTA_ST_IDLE;
               next_r.ovf = 1'b1;
            end else if (f_empty && r.paused && !r.out_valid) begin
               next_r.st = RTA_ST_IDLE;
            end else if (frame_full && !r.out_valid) begin
               next_r.st       = RTA_ST_SYNC;
               next_r.sync_cnt = '0;
            end
         end
         RTA_ST_RX: begin
            // Count one past the limit so an over-long message is recognised
            // and not replayed; the store only holds the limit.
            if (rx_byte_i && r.rpt_bytes <= 11'(`RTA_RPT_MAX_BYTES)) begin
               next_r.rpt_bytes = r.rpt_bytes + 11'h1;
            end
            if (settings_cmd_i && r.mode == RTA_MODE_RX_PRI) begin
               next_r.st = RTA_ST_IDLE;
               next_r.rx_keep = 1'b0;
            end else if (term_valid_i && r.mode == RTA_MODE_TX_PRI) begin
               next_r.st       = RTA_ST_SYNC;
               next_r.rx_keep  = 1'b0;
               next_r.sync_cnt = '0;
            end else if (rx_lost_i) begin
               next_r.st      = RTA_ST_IDLE;
               next_r.rx_keep = 1'b0;
            end else if (rx_end_i) begin
               next_r.rx_keep = 1'b0;
               // Repeat valid messages; advanced modes decide by content.
               if (rx_ok_i && r.rpt_bytes <= 11'(`RTA_RPT_MAX_BYTES) &&
                   (r.mode == RTA_MODE_REPEAT ||
                    (is_adv(r.mode) && rx_fwd_i))) begin
                  next_r.st = RTA_ST_FWD;
               end else begin
                  next_r.st = RTA_ST_IDLE;
               end
            end
         end
         RTA_ST_FWD: begin
            // Terminal data waits in the FIFO until the stored message has been resent.
            if (fwd_done_i) begin
               next_r.st = RTA_ST_IDLE;
            end
         end
         default: next_r.st = RTA_ST_IDLE;
      endcase
   end

   // State register; clock enable freezes everything.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         r          <= '0;
         r.st       <= RTA_ST_IDLE;
         r.mode     <= RTA_MODE_TX_PRI;
         r.paused   <= 1'b1;
         r.pause_chars <= `RTA_PAUSE_DEF_CHARS;
      end else if (ce_i) begin
         r <= next_r;
      end
   end

   // Outputs from flip-flops except the handshake.
   assign term_ready_o = f_ready;
   assign tx_on_o      = (r.st == RTA_ST_SYNC) || (r.st == RTA_ST_TX);
   assign sync_req_o   = (r.st == RTA_ST_SYNC);
   assign tx_valid_o   = r.out_valid;
   assign tx_data_o    = r.out_data;
   assign fwd_req_o    = (r.st == RTA_ST_FWD);
   assign rx_accept_o  = r.rx_keep;
   assign rx_drop_o    = r.drop;
   assign diag_en_o    = is_adv(r.mode);
   assign overflow_o   = r.ovf;

   // Checks beside the logic.
   // A replay holds until the far side reports it finished; nothing else goes out.
   sequence s_fwd_cycle;
      ce_i && r.st == RTA_ST_FWD && !fwd_done_i;
   endsequence
   a_fwd_blocks_tx: assert property (@(posedge mclk_i) disable iff (rst_i)
      s_fwd_cycle |=> (fwd_req_o && !tx_on_o)) else $error("tx during forward");
   a_diag_basic: assert property (@(posedge mclk_i) disable iff (rst_i)
      (r.mode == RTA_MODE_RX_PRI || r.mode == RTA_MODE_TX_PRI || r.mode == RTA_MODE_REPEAT)
      |-> !diag_en_o) else $error("diag in basic");
   a_ovf_ends_tx: assert property (@(posedge mclk_i) disable iff (rst_i)
      (ce_i && r.st == RTA_ST_TX && ovf_ev) |=> (r.st == RTA_ST_IDLE && overflow_o))
      else $error("overflow did not end tx");
   a_lost_abandon: assert property (@(posedge mclk_i) disable iff (rst_i)
      (ce_i && r.st == RTA_ST_RX && rx_lost_i && !settings_cmd_i && !term_valid_i)
      |=> (r.st == RTA_ST_IDLE && !rx_accept_o)) else $error("lost rx kept");
   a_settings_abort: assert property (@(posedge mclk_i) disable iff (rst_i)
      (ce_i && r.st == RTA_ST_RX && settings_cmd_i && r.mode == RTA_MODE_RX_PRI)
      |=> r.st == RTA_ST_IDLE) else $error("settings did not abort");
   a_txpri_abort: assert property (@(posedge mclk_i) disable iff (rst_i)
      (ce_i && r.st == RTA_ST_RX && term_valid_i && !settings_cmd_i &&
       r.mode == RTA_MODE_TX_PRI) |=> sync_req_o) else $error("no tx abort");
   a_rxpri_wait: assert property (@(posedge mclk_i) disable iff (rst_i)
      (r.st == RTA_ST_RX && r.mode == RTA_MODE_RX_PRI) |-> !tx_on_o)
      else $error("tx during rx");
   a_family_drop: assert property (@(posedge mclk_i) disable iff (rst_i)
      (ce_i && r.st == RTA_ST_IDLE && rx_start_i && is_adv(r.mode) != rx_adv_i)
      |=> (rx_drop_o && r.st == RTA_ST_IDLE)) else $error("foreign kept");
   a_sync_first: assert property (@(posedge mclk_i) disable iff (rst_i)
      (ce_i && r.st != RTA_ST_TX && next_r.st == RTA_ST_TX) |-> sync_req_o)
      else $error("tx without sync");
   // A full frame hands over to a fresh sync unless the frame ends first.
   sequence s_frame_limit;
      ce_i && r.st == RTA_ST_TX && frame_full && !r.out_valid && !ovf_ev &&
      !(f_empty && r.paused);
   endsequence
   a_frame_resync: assert property (@(posedge mclk_i) disable iff (rst_i)
      s_frame_limit |=> (sync_req_o && !tx_valid_o)) else $error("frame limit ignored");
   // The start delay keeps the transmitter off while bytes collect.
   a_delay_quiet: assert property (@(posedge mclk_i) disable iff (rst_i)
      (ce_i && r.st == RTA_ST_IDLE && !rx_start_i && !f_empty && tx_delay_ms_i != 16'h0)
      |=> (!tx_on_o && !sync_req_o)) else $error("delay skipped");
   // Empty buffer plus pause drops the transmitter on the next edge.
   a_pause_end: assert property (@(posedge mclk_i) disable iff (rst_i)
      (ce_i && r.st == RTA_ST_TX && !ovf_ev && f_empty && r.paused && !r.out_valid)
      |=> !tx_on_o) else $error("pause did not end tx");
   // The mode only moves on a load with a legal code; stray codes are ignored.
   a_mode_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
      (!ce_i || !(mode_valid_i && mode_i <= 3'h4)) |=> $stable(r.mode))
      else $error("mode changed without load");
endmodule // rta_arbiter

// ==== src/rta_cfg.svh ====
// Purpose: Constants for the radio transmit/receive arbitration block.
// Assumes: 100 MHz device clock.
// Notes:   Offsets and counts are held here once; the package holds types.
`ifndef RTA_CFG_SVH
`define RTA_CFG_SVH
`define RTA_CLK_MHZ          100
`define RTA_PAUSE_DEF_CHARS  8'h03
`define RTA_TXDLY_MAX_MS     65000
`define RTA_CYC_PER_MS       (`RTA_CLK_MHZ * 1000)
`define RTA_RESYNC_US        20000
`define RTA_RESYNC_CYC       (`RTA_RESYNC_US * `RTA_CLK_MHZ)
`define RTA_RPT_MAX_BYTES    1024
`define RTA_FIFO_DEPTH       16
`define RTA_DATA_W           8
`endif

// ==== src/rta_pkg.sv ====
// Purpose: Types for the radio transmit/receive arbitration block.
// Assumes: Included configuration header defines sizes.
// Notes:   Modes use the documented ordering; transmit priority is default.
package rta_pkg;
   typedef enum logic [2:0] {
      RTA_MODE_RX_PRI  = 3'h0,
      RTA_MODE_TX_PRI  = 3'h1,
      RTA_MODE_REPEAT  = 3'h2,
      RTA_MODE_ADV_MST = 3'h3,
      RTA_MODE_ADV_SLV = 3'h4
   } rta_mode_t;

   typedef enum logic [2:0] {
      RTA_ST_IDLE  = 3'h0,
      RTA_ST_DELAY = 3'h1,
      RTA_ST_SYNC  = 3'h2,
      RTA_ST_TX    = 3'h3,
      RTA_ST_RX    = 3'h4,
      RTA_ST_FWD   = 3'h5
   } rta_state_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
      logic       last;
   } rta_byte_t;
endpackage

// ==== src/rta_fifo.sv ====
// Purpose: Synchronous FIFO holding terminal data on its way to the radio.
// Assumes: One clock, synchronous active-high reset, clock enable.
// Notes:   Ready on the write side drops when full so the source stalls.
`include "rta_cfg.svh"
module rta_fifo
   import rta_pkg::*;
#(
   parameter int WIDTH = `RTA_DATA_W,
   parameter int DEPTH = `RTA_FIFO_DEPTH
) (
   input  wire logic             mclk_i,    // Device clock.
   input  wire logic             rst_i,     // Synchronous reset.
   input  wire logic             ce_i,      // Clock enable.
   input  wire logic             wvalid_i,  // Write data valid.
   output logic                  wready_o,  // Space available.
   input  wire logic [WIDTH-1:0] wdata_i,   // Write data.
   output logic                  rvalid_o,  // Data available.
   input  wire logic             rready_i,  // Reader takes data.
   output logic [WIDTH-1:0]      rdata_o,   // Head of queue.
   output logic                  empty_o    // Nothing stored.
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wp;
   logic [AW:0]      rp;
   logic             full;

   // Pointers carry one extra bit so full and empty are distinguishable.
   assign full     = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
   assign empty_o  = (wp == rp);
   assign wready_o = !full;
   assign rvalid_o = !empty_o;
   assign rdata_o  = mem[rp[AW-1:0]];

   // Storage and pointer update.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         wp <= '0;
         rp <= '0;
      end else if (ce_i) begin
         if (wvalid_i && !full) begin
            mem[wp[AW-1:0]] <= wdata_i;
            wp              <= wp + 1'b1;
         end
         if (rready_i && !empty_o) begin
            rp <= rp + 1'b1;
         end
      end
   end
endmodule // rta_fifo

// ==== verif/rta_radio_model.sv ====
// Purpose: Far side model: modulator, remote modems and store replay.
// Assumes: Driven off the falling edge of the device clock.
// Notes:   Stall holds the modulator busy so the terminal buffer backs up.
module rta_radio_model
   import rta_pkg::*;
(
   input  wire logic mclk_i,        // Device clock.
   input  wire logic stall_i,       // Hold modulator busy.
   input  wire logic fwd_req_i,     // Replay requested.
   output logic      radio_ready_o, // Modulator takes a byte.
   output logic      fwd_done_o,    // Replay finished.
   output logic      rx_start_o,    // Frame start found.
   output logic      rx_adv_o,      // Sender in advanced mode.
   output logic      rx_lost_o,     // Reception lost.
   output logic      rx_end_o,      // Reception ended.
   output logic      rx_ok_o,       // Message valid.
   output logic      rx_fwd_o,      // Content asks for repeat.
   output logic      rx_byte_o      // Received byte strobe.
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] fcnt;

   // Quiet line at time zero; qualifiers are levels, strobes are pulses.
   initial begin
      {rx_start_o, rx_adv_o, rx_lost_o, rx_end_o} = 4'h0;
      {rx_ok_o, rx_fwd_o, rx_byte_o, fwd_done_o, fcnt} = 8'h00;
   end
   assign radio_ready_o = !stall_i;

   // Replay takes a few cycles, so the arbiter must hold its request.
   always @(negedge mclk_i) begin
      fwd_done_o <= fwd_req_i && (fcnt == 4'h6);
      fcnt <= fwd_req_i ? fcnt + 4'h1 : 4'h0;
   end

   // A remote modem starts a frame with the given family and validity.
   task automatic rx_begin(input logic adv, input logic ok);
      @(negedge mclk_i) {rx_adv_o, rx_ok_o, rx_fwd_o, rx_start_o} = {adv, ok, 2'h3};
      @(negedge mclk_i) rx_start_o = 1'b0;
   endtask

   // Two bytes arrive, then the frame ends or is lost.
   task automatic rx_finish(input logic lost);
      repeat (2) @(negedge mclk_i) rx_byte_o = 1'b1;
      @(negedge mclk_i) {rx_byte_o, rx_lost_o, rx_end_o} = {1'b0, lost, !lost};
      @(negedge mclk_i) {rx_lost_o, rx_end_o} = 2'h0;
   endtask
endmodule // rta_radio_model

// ==== verif/radio_tx_rx_arbitration_test.sv ====
// Purpose: Self-checking bench for the transmit/receive arbiter.
// Assumes: Inputs change on the falling edge; resync 10 and ms 5 cycles.
// Notes:   Reset before each scenario from t_ovf on keeps each one free of leftovers.
module radio_tx_rx_arbitration_test
   import rta_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk, rst, mode_valid, term_valid, settings_cmd, stall, term_ready;
   logic        rx_start, rx_adv, rx_lost, rx_end, rx_ok, rx_fwd, rx_byte, radio_ready;
   logic        fwd_done, tx_on, sync_req, tx_valid, fwd_req, rx_accept, rx_drop;
   logic        diag_en, overflow;
   logic [2:0]  mode;
   logic [7:0]  term_data, tx_data;
   logic [15:0] tx_delay;
   logic [15:0] sync_int;
   logic [7:0]  pause_chars;
   logic        ce;
   int          n_mismatch, num_checks, cyc, k;

   rta_arbiter #(.RESYNC_CYC(10), .MS_CYC(5)) rta_arbiter_i (
      .mclk_i(mclk), .rst_i(rst), .ce_i(ce), .mode_valid_i(mode_valid),
      .mode_i(mode), .pause_chars_i(pause_chars), .char_cyc_i(16'h0004),
      .tx_delay_ms_i(tx_delay), .sync_int_i(sync_int), .term_valid_i(term_valid),
      .term_data_i(term_data), .settings_cmd_i(settings_cmd), .term_ready_o(term_ready),
      .rx_start_i(rx_start), .rx_adv_i(rx_adv), .rx_lost_i(rx_lost), .rx_end_i(rx_end),
      .rx_ok_i(rx_ok), .rx_fwd_i(rx_fwd), .rx_byte_i(rx_byte),
      .radio_ready_i(radio_ready), .fwd_done_i(fwd_done), .tx_on_o(tx_on),
      .sync_req_o(sync_req), .tx_valid_o(tx_valid), .tx_data_o(tx_data),
      .fwd_req_o(fwd_req), .rx_accept_o(rx_accept), .rx_drop_o(rx_drop),
      .diag_en_o(diag_en), .overflow_o(overflow));

   rta_radio_model rta_radio_model_i (
      .mclk_i(mclk), .stall_i(stall), .fwd_req_i(fwd_req), .radio_ready_o(radio_ready),
      .fwd_done_o(fwd_done), .rx_start_o(rx_start), .rx_adv_o(rx_adv),
      .rx_lost_o(rx_lost), .rx_end_o(rx_end), .rx_ok_o(rx_ok), .rx_fwd_o(rx_fwd),
      .rx_byte_o(rx_byte));

   // Free-running 100 MHz clock.
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // Cuts a hang short; the whole run needs well under this many cycles.
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 8000) begin
         n_mismatch++;
         close_out();
      end
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic close_out;
      $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // Selects an output by number so one bounded wait serves them all.
   function automatic logic sig(input int s);
      case (s)
         0: return sync_req;
         1: return tx_on;
         2: return tx_valid;
         3: return fwd_req;
         4: return rx_drop;
         default: return overflow;
      endcase
   endfunction

   task automatic wt(input int s, input logic v, input int lim);
      int n;
      n = 0;
      while (sig(s) !== v && n < lim) begin
         @(negedge mclk);
         n++;
      end
      chk(16'(n < lim), 16'h0001);
   endtask

   task automatic do_reset;
      @(negedge mclk) rst = 1'b1;
      repeat (20) @(negedge mclk);
      rst = 1'b0;
   endtask

   // One terminal byte; the strobe drops a full cycle before the next.
   task automatic send(input logic [7:0] d);
      @(negedge mclk) {term_valid, term_data} = {1'b1, d};
      @(negedge mclk) term_valid = 1'b0;
   endtask

   task automatic set_mode(input logic [2:0] m);
      @(negedge mclk) {mode_valid, mode} = {1'b1, m};
      @(negedge mclk) mode_valid = 1'b0;
   endtask

   task automatic t_tx;
      chk(diag_en, 0);
      send(8'hA5);
      wt(0, 1'b1, 3);
      chk(tx_on, 1);
      wt(2, 1'b1, 20);
      chk(tx_data, 8'hA5);
      chk(sync_req, 0);
      send(8'h5A);
      repeat (8) @(negedge mclk);
      chk(tx_on, 1);
      wt(1, 1'b0, 20);
   endtask

   // A start delay of 2 ms is 10 shortened cycles.
   task automatic t_delay;
      tx_delay = 16'h0002;
      send(8'h42);
      repeat (6) @(negedge mclk);
      chk(sync_req, 0);
      wt(0, 1'b1, 12);
      tx_delay = 16'h0000;
      wt(1, 1'b0, 60);
   endtask

   task automatic t_ovf;
      do_reset();
      stall = 1'b1;
      k = 0;
      while (term_ready === 1'b1 && k < 40) begin
         send(8'(k));
         k++;
      end
      chk(16'(k > 15), 16'h0001);
      send(8'hFF);
      wt(5, 1'b1, 3);
      wt(1, 1'b0, 3);
      stall = 1'b0;
   endtask

   task automatic t_abort;
      do_reset();
      rta_radio_model_i.rx_begin(1'b0, 1'b1);
      chk(rx_accept, 1);
      rta_radio_model_i.rx_finish(1'b1);
      @(negedge mclk);
      chk(rx_accept, 0);
      rta_radio_model_i.rx_begin(1'b0, 1'b1);
      send(8'h3C);
      wt(1, 1'b1, 3);
      chk(rx_accept, 0);
   endtask

   task automatic t_rxpri;
      do_reset();
      set_mode(3'h0);
      rta_radio_model_i.rx_begin(1'b0, 1'b1);
      send(8'h11);
      repeat (4) @(negedge mclk);
      chk(tx_on, 0);
      rta_radio_model_i.rx_finish(1'b0);
      wt(1, 1'b1, 4);
      wt(1, 1'b0, 60);
      rta_radio_model_i.rx_begin(1'b0, 1'b1);
      @(negedge mclk) settings_cmd = 1'b1;
      @(negedge mclk) settings_cmd = 1'b0;
      @(negedge mclk);
      chk(rx_accept, 0);
   endtask

   // Every mode code meets a frame from the other family.
   task automatic t_family;
      for (int m = 0; m < 5; m++) begin
         do_reset();
         set_mode(3'(m));
         rta_radio_model_i.rx_begin(m < 3, 1'b1);
         chk(diag_en, 16'(m > 2));
         wt(4, 1'b1, 3);
         rta_radio_model_i.rx_finish(1'b1);
      end
   endtask

   task automatic t_rpt;
      do_reset();
      set_mode(3'h2);
      rta_radio_model_i.rx_begin(1'b0, 1'b1);
      send(8'h77);
      repeat (3) @(negedge mclk);
      chk(tx_on, 0);
      rta_radio_model_i.rx_finish(1'b0);
      wt(3, 1'b1, 4);
      wt(3, 1'b0, 20);
      wt(0, 1'b1, 20);
      wt(1, 1'b0, 60);
      rta_radio_model_i.rx_begin(1'b0, 1'b0);
      rta_radio_model_i.rx_finish(1'b0);
      repeat (6) @(negedge mclk);
      chk(fwd_req, 0);
      set_mode(3'h3);
      rta_radio_model_i.rx_begin(1'b1, 1'b1);
      rta_radio_model_i.rx_finish(1'b0);
      wt(3, 1'b1, 4);
      wt(3, 1'b0, 20);
   endtask

   // Clock enable low freezes the sync phase; a six-character pause keeps the link up.
   task automatic t_hold;
      do_reset();
      pause_chars = 8'h06;
      send(8'h44);
      wt(0, 1'b1, 3);
      ce = 1'b0;
      repeat (15) @(negedge mclk);
      chk(sync_req, 1);
      ce = 1'b1;
      wt(2, 1'b1, 20);
      repeat (10) @(negedge mclk);
      chk(tx_on, 1);
      wt(1, 1'b0, 20);
      pause_chars = 8'h00;
   endtask

   // A frame limit of two bytes forces a fresh sync before the third byte.
   task automatic t_sync;
      do_reset();
      sync_int = 16'h0002;
      send(8'h11);
      send(8'h22);
      send(8'h33);
      wt(0, 1'b1, 3);
      wt(0, 1'b0, 15);
      wt(0, 1'b1, 8);
      chk(tx_data, 8'h22);
      wt(2, 1'b1, 20);
      chk(tx_data, 8'h33);
      wt(1, 1'b0, 60);
      sync_int = 16'h0000;
   endtask

   // Main sequence; every input has a value at time zero.
   initial begin
      {rst, mode_valid, term_valid, settings_cmd, stall} = 5'h10;
      {ce, pause_chars, sync_int} = 25'h1000000;
      {mode, term_data, tx_delay} = 27'h0;
      {n_mismatch, num_checks, cyc} = '0;
      do_reset();
      chk(term_ready, 1);
      t_tx();
      t_delay();
      t_ovf();
      t_abort();
      t_rxpri();
      t_family();
      t_rpt();
      t_hold();
      t_sync();
      close_out();
   end
endmodule // radio_tx_rx_arbitration_test
